// file: shared/bss_pkg.sv
/*
 * Package for the ballast startup mode sequencer: modes, timing counts,
 * and the packed carriers for comparator inputs and switch outputs.
 * Assumes a 25 MHz system clock and comparator levels from analog blocks.
 */
package bss_pkg;

	localparam int CLK_HZ = 25000000;
	localparam int DEADTIME_NS = 1500;
	localparam int CLK_PERIOD_NS = 40;
	// Least time rounds up
	localparam int DEADTIME_CYC = (DEADTIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAULT_EVENT_COUNT = 60;
	localparam int CNT_W = 6;
	// Half periods in clock cycles: soft start, preheat, run
	localparam int SOFT_HALF_CYC = 100;
	localparam int PREHEAT_HALF_CYC = 184;
	localparam int RUN_HALF_CYC = 275;
	localparam int SOFT_STEP_CYC = 4;
	localparam int HALF_W = 10;

	typedef enum logic [2:0] {
		BSS_LOCKOUT,
		BSS_PREHEAT,
		BSS_STRIKE,
		BSS_SETTLE,
		BSS_STEADY,
		BSS_FAULT
	} bss_mode_t;

	// Comparator results, all asynchronous to i_mclk
	typedef struct packed {
		logic supply_ok;
		logic bus_above_on;
		logic bus_below_off;
		logic sense_below_reset;
		logic sense_above_shutdown;
		logic high_side_ok;
		logic cph_above_two_thirds;
		logic cph_below_one_third;
		logic cph_above_half;
		logic cs_above_thresh;
	} bss_cmp_t;

	typedef struct packed {
		logic bottom_gate_drive;
		logic top_gate_drive;
		logic preheat_timer_discharge;
		logic ramp_control_ground;
		logic ramp_control_nudge;
	} bss_drv_t;

endpackage

// file: src/bss_sync.sv
/*
 * Two-flop synchroniser for a vector of asynchronous levels.
 * Assumes inputs are quasi-static comparator levels.
 */
`timescale 1ns/1ns
module bss_sync #(
	parameter int W = 1
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;

endmodule

// file: src/bss_sequencer.sv
/*
 * Startup mode sequencer for a half-bridge ballast: lockout, preheat,
 * strike, settle, steady and fault, plus gate drive with deadtime and
 * the over-current event counter.
 * Assumes i_reset_n is the supply lockout and comparators are asynchronous.
 */
`timescale 1ns/1ns
// Operation
// R1: Start only with supply, bus, sense good
// R2: Top drive waits for high-side supply
// R3: Complementary 50% drive with 1.5us deadtime
// R4: Lockout: drives low, timer grounded
// R5: Preheat releases timer ground switch
// R6: Soft start, step to preheat, ramp grounded
// R7: Preheat ends at two thirds supply
// R8: Preheat enables over-current counter
// R9: First two-thirds discharges timer to third
// R10: Strike releases ramp ground switch
// R11: Strike over-current nudges ramp each cycle
// R12: Strike ends when timer reaches half
// R13: Settle: single over-current means fault
// R14: Second two-thirds enters steady, counter on
// R15: Counter up/down, 60 events latch fault
// R16: Counter disabled during strike
// R17: Synchronised comparators, lockout on supply loss
module bss_sequencer #(
	parameter int DEAD_CYC = bss_pkg::DEADTIME_CYC,
	parameter int EVENTS = bss_pkg::FAULT_EVENT_COUNT
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire bss_pkg::bss_cmp_t i_cmp,
	output bss_pkg::bss_drv_t o_drv,
	output bss_pkg::bss_mode_t o_mode,
	output logic [bss_pkg::CNT_W-1:0] o_fault_event_count
);

	localparam logic [bss_pkg::HALF_W-1:0] SOFT_H = bss_pkg::HALF_W'(bss_pkg::SOFT_HALF_CYC);
	localparam logic [bss_pkg::HALF_W-1:0] PH_H = bss_pkg::HALF_W'(bss_pkg::PREHEAT_HALF_CYC);
	localparam logic [bss_pkg::HALF_W-1:0] RUN_H = bss_pkg::HALF_W'(bss_pkg::RUN_HALF_CYC);
	localparam logic [bss_pkg::HALF_W-1:0] STEP = bss_pkg::HALF_W'(bss_pkg::SOFT_STEP_CYC);
	localparam logic [bss_pkg::HALF_W-1:0] DEAD = bss_pkg::HALF_W'(DEAD_CYC);
	localparam logic [bss_pkg::CNT_W-1:0] EV_MAX = bss_pkg::CNT_W'(EVENTS);

	bss_pkg::bss_cmp_t cmp;

	// R17: two-flop synchronisers
	bss_sync #(.W($bits(bss_pkg::bss_cmp_t))) u_sync (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_async(i_cmp),
		.o_sync(cmp)
	);

	bss_pkg::bss_mode_t mode_r, mode_nxt;
	logic [bss_pkg::HALF_W-1:0] half_r, half_nxt;
	logic [bss_pkg::HALF_W-1:0] tick_r, tick_nxt;
	logic phase_r, phase_nxt;
	logic hs_on_r, hs_on_nxt;
	logic cph_dis_r, cph_dis_nxt;
	logic oc_seen_r, oc_seen_nxt;
	logic [bss_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic lo_r, lo_nxt;
	logic ho_r, ho_nxt;
	logic nudge_r, nudge_nxt;
	logic cycle_end;
	logic switching;
	logic oc_now;

	assign switching = (mode_r != bss_pkg::BSS_LOCKOUT) && (mode_r != bss_pkg::BSS_FAULT);
	// One bottom-drive cycle ends where low phase ends
	assign cycle_end = switching && phase_r && (tick_r + 1'b1 >= half_r);
	// Event on the last low-side tick still counts, though clear beats set in oc_seen_r
	assign oc_now = oc_seen_r || (lo_r && cmp.cs_above_thresh);

	always_comb begin
		mode_nxt = mode_r;
		half_nxt = half_r;
		tick_nxt = tick_r;
		phase_nxt = phase_r;
		hs_on_nxt = hs_on_r;
		cph_dis_nxt = cph_dis_r;
		oc_seen_nxt = oc_seen_r;
		cnt_nxt = cnt_r;
		lo_nxt = 1'b0;
		ho_nxt = 1'b0;
		nudge_nxt = 1'b0;
		// Bus drop or shutdown restarts from the beginning
		if (switching && (cmp.bus_below_off || cmp.sense_above_shutdown)) begin
			mode_nxt = bss_pkg::BSS_LOCKOUT;
		end else begin
			unique case (mode_r)
				bss_pkg::BSS_LOCKOUT: begin
					// R4: oscillator stopped, counter cleared
					tick_nxt = '0;
					phase_nxt = 1'b1;
					hs_on_nxt = 1'b0;
					cph_dis_nxt = 1'b0;
					cnt_nxt = '0;
					oc_seen_nxt = 1'b0;
					// R1: three start conditions
					if (cmp.supply_ok && cmp.bus_above_on && cmp.sense_below_reset) begin
						mode_nxt = bss_pkg::BSS_PREHEAT;
						// R6: soft-start frequency first
						half_nxt = SOFT_H;
					end
				end
				bss_pkg::BSS_PREHEAT: begin
					// R7: two thirds ends preheat
					if (cmp.cph_above_two_thirds) begin
						mode_nxt = bss_pkg::BSS_STRIKE;
						// R9: discharge to one third
						cph_dis_nxt = 1'b1;
						cnt_nxt = '0;
					end
				end
				bss_pkg::BSS_STRIKE: begin
					// R9: release once at one third
					if (cph_dis_r && cmp.cph_below_one_third) begin
						cph_dis_nxt = 1'b0;
					end
					// R12: half supply ends strike
					if (!cph_dis_r && cmp.cph_above_half) begin
						mode_nxt = bss_pkg::BSS_SETTLE;
					end
				end
				bss_pkg::BSS_SETTLE: begin
					// R13: single event faults
					if (cycle_end && oc_now) begin
						mode_nxt = bss_pkg::BSS_FAULT;
					end else if (cmp.cph_above_two_thirds) begin
						// R14: second crossing, counter re-enabled
						mode_nxt = bss_pkg::BSS_STEADY;
						cnt_nxt = '0;
					end
				end
				bss_pkg::BSS_STEADY: begin
				end
				bss_pkg::BSS_FAULT: begin
					// R15: drives latched low until lockout
					hs_on_nxt = 1'b0;
				end
			endcase
		end
		if (switching && mode_nxt != bss_pkg::BSS_LOCKOUT) begin
			// R6: step down from soft start to preheat
			if (mode_r == bss_pkg::BSS_PREHEAT && cycle_end && half_r < PH_H) begin
				half_nxt = (PH_H - half_r > STEP) ? half_r + STEP : PH_H;
			end
			// R10: ramp released, frequency sweeps toward run
			if (mode_r != bss_pkg::BSS_PREHEAT && cycle_end && half_r < RUN_H) begin
				half_nxt = half_r + 1'b1;
			end
			// R11: over-current in strike raises frequency
			if (mode_r == bss_pkg::BSS_STRIKE && cycle_end && oc_now) begin
				nudge_nxt = 1'b1;
				if (half_r > PH_H) begin
					half_nxt = half_r - STEP;
				end
			end
			// R2: high side joins once its supply is up
			// Only at a half boundary, so its first pulse is full width
			if (cmp.high_side_ok && tick_r == '0) begin
				hs_on_nxt = 1'b1;
			end
			// Over-current only counts while bottom drive is on
			if (lo_r && cmp.cs_above_thresh) begin
				oc_seen_nxt = 1'b1;
			end
			if (cycle_end) begin
				oc_seen_nxt = 1'b0;
				// R8: counter runs in preheat and steady
				// R16: frozen in strike
				if (mode_r == bss_pkg::BSS_PREHEAT || mode_r == bss_pkg::BSS_STEADY) begin
					// R15: up on event, down otherwise
					if (oc_now) begin
						cnt_nxt = cnt_r + 1'b1;
						if (cnt_r + 1'b1 >= EV_MAX) begin
							mode_nxt = bss_pkg::BSS_FAULT;
						end
					end else if (cnt_r != '0) begin
						cnt_nxt = cnt_r - 1'b1;
					end
				end
			end
			// R3: equal halves, deadtime at start of each
			if (tick_r + 1'b1 >= half_r) begin
				tick_nxt = '0;
				phase_nxt = !phase_r;
			end else begin
				tick_nxt = tick_r + 1'b1;
			end
			if (mode_nxt != bss_pkg::BSS_FAULT && tick_r >= DEAD) begin
				lo_nxt = phase_r;
				ho_nxt = !phase_r && hs_on_r;
			end
		end
	end

	// R17: asynchronous lockout on supply loss
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode_r <= bss_pkg::BSS_LOCKOUT;
			half_r <= '0;
			tick_r <= '0;
			phase_r <= 1'b1;
			hs_on_r <= 1'b0;
			cph_dis_r <= 1'b0;
			oc_seen_r <= 1'b0;
			cnt_r <= '0;
			lo_r <= 1'b0;
			ho_r <= 1'b0;
			nudge_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			half_r <= half_nxt;
			tick_r <= tick_nxt;
			phase_r <= phase_nxt;
			hs_on_r <= hs_on_nxt;
			cph_dis_r <= cph_dis_nxt;
			oc_seen_r <= oc_seen_nxt;
			cnt_r <= cnt_nxt;
			lo_r <= lo_nxt;
			ho_r <= ho_nxt;
			nudge_r <= nudge_nxt;
		end
	end

	always_comb begin
		o_drv.bottom_gate_drive = lo_r;
		o_drv.top_gate_drive = ho_r;
		// R4: timer grounded in lockout and fault
		// R5: released in preheat
		o_drv.preheat_timer_discharge = (mode_r == bss_pkg::BSS_LOCKOUT) ||
			(mode_r == bss_pkg::BSS_FAULT) || cph_dis_r;
		// R6: ramp grounded in preheat
		o_drv.ramp_control_ground = (mode_r == bss_pkg::BSS_LOCKOUT) ||
			(mode_r == bss_pkg::BSS_PREHEAT) || (mode_r == bss_pkg::BSS_FAULT);
		o_drv.ramp_control_nudge = nudge_r;
	end
	assign o_mode = mode_r;
	assign o_fault_event_count = cnt_r;

	property p_no_overlap;
		@(posedge i_mclk) disable iff (!i_reset_n) !(lo_r && ho_r);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("drives overlap"); // R3

	property p_dead_lo_ho;
		@(posedge i_mclk) disable iff (!i_reset_n) $fell(lo_r) |-> !ho_r [*8];
	endproperty
	a_dead_lo_ho: assert property (p_dead_lo_ho) else $error("deadtime short"); // R3

	property p_lockout_low;
		@(posedge i_mclk) disable iff (!i_reset_n)
			mode_r == bss_pkg::BSS_LOCKOUT |-> ##1 (!lo_r && !ho_r);
	endproperty
	a_lockout_low: assert property (p_lockout_low) else $error("drive in lockout"); // R4

	property p_start;
		@(posedge i_mclk) disable iff (!i_reset_n)
			$rose(mode_r == bss_pkg::BSS_PREHEAT) |-> $past(cmp.supply_ok && cmp.bus_above_on
			&& cmp.sense_below_reset);
	endproperty
	a_start: assert property (p_start) else $error("bad start"); // R1

	property p_ho_needs_hs;
		@(posedge i_mclk) disable iff (!i_reset_n) ho_r |-> hs_on_r;
	endproperty
	a_ho_needs_hs: assert property (p_ho_needs_hs) else $error("top early"); // R2

	property p_ramp_preheat;
		@(posedge i_mclk) disable iff (!i_reset_n)
			mode_r == bss_pkg::BSS_PREHEAT |-> o_drv.ramp_control_ground;
	endproperty
	a_ramp_preheat: assert property (p_ramp_preheat) else $error("ramp free"); // R6

	property p_strike_cnt;
		@(posedge i_mclk) disable iff (!i_reset_n)
			mode_r == bss_pkg::BSS_STRIKE && $past(mode_r == bss_pkg::BSS_STRIKE)
			|-> cnt_r == $past(cnt_r);
	endproperty
	a_strike_cnt: assert property (p_strike_cnt) else $error("count in strike"); // R16

	property p_cnt_fault;
		@(posedge i_mclk) disable iff (!i_reset_n)
			mode_r == bss_pkg::BSS_STEADY && cnt_r == EV_MAX - 1 && cycle_end && oc_seen_r
			|-> ##1 mode_r == bss_pkg::BSS_FAULT;
	endproperty
	a_cnt_fault: assert property (p_cnt_fault) else $error("no fault at 60"); // R15

	property p_fault_latched;
		@(posedge i_mclk) disable iff (!i_reset_n)
			mode_r == bss_pkg::BSS_FAULT |-> ##1 (!lo_r && !ho_r);
	endproperty
	a_fault_latched: assert property (p_fault_latched) else $error("drive in fault"); // R15

	c_strike: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
		mode_r == bss_pkg::BSS_STRIKE ##1 mode_r == bss_pkg::BSS_SETTLE);
	c_steady: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
		mode_r == bss_pkg::BSS_STEADY);
	c_fault: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
		mode_r == bss_pkg::BSS_FAULT);

endmodule

// file: tb/bss_stage_model.sv
/*
 * Half-bridge stage and sense network: timer node, bootstrap, current sense.
 * Assumes drive levels from the sequencer and a bench-set overcurrent flag.
 */
`timescale 1ns/1ns
module bss_stage_model #(
	parameter int STEP = 32
) (
	input wire logic i_mclk,
	input wire logic i_oc,
	input wire bss_pkg::bss_drv_t i_drv,
	output logic [4:0] o_cmp
);
	int lvl = 0;
	int tick = 0;
	int boots = 0;
	logic lo_d = 1'b0;
	always @(posedge i_mclk) begin
		lo_d <= i_drv.bottom_gate_drive;
		if (i_drv.preheat_timer_discharge && lvl == 0)
			boots <= 0;
		else if (i_drv.bottom_gate_drive && !lo_d && boots < 3)
			boots <= boots + 1;
		// grounded node sinks fast, released node charges slowly
		if (i_drv.preheat_timer_discharge)
			lvl <= (lvl > 16) ? lvl - 16 : 0;
		else if (tick == STEP - 1 && lvl < 300)
			lvl <= lvl + 1;
		tick <= (tick == STEP - 1) ? 0 : tick + 1;
	end
	// Sense resistor only carries current while the low side conducts
	assign o_cmp = {boots == 3, lvl > 200, lvl < 100, lvl >= 150,
		i_oc & i_drv.bottom_gate_drive};
endmodule

// file: tb/tb_top.sv
/*
 * Bench for the mode sequencer: start table, full startup run, faults.
 * Assumes the stage model closes the loop on timer, bootstrap and sense.
 */
`timescale 1ns/1ns
module tb_top;
	localparam int DEAD = bss_pkg::DEADTIME_CYC;
	logic i_mclk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [4:0] env = 5'h00;
	logic oc = 1'b0;
	logic [4:0] stage;
	bss_pkg::bss_cmp_t i_cmp;
	bss_pkg::bss_drv_t o_drv;
	bss_pkg::bss_mode_t o_mode;
	logic [5:0] cnt;
	int err_total = 0;
	int checked = 0;
	int cyc = 0;
	int gap = 0;
	int lo_len = 0;
	int ho_len = 0;
	int ho_last = 0;
	int ho_seen = 0;
	// Supply, bus, sense low, start expected
	logic [3:0] rows [4] = '{4'hF, 4'h6, 4'hA, 4'hC};
	assign i_cmp = {env, stage};
	bss_sequencer #(.DEAD_CYC(DEAD), .EVENTS(4)) dut_u (.i_mclk(i_mclk),
		.i_reset_n(i_reset_n), .i_cmp(i_cmp), .o_drv(o_drv), .o_mode(o_mode),
		.o_fault_event_count(cnt));
	bss_stage_model #(.STEP(32)) stage_u (.i_mclk(i_mclk), .i_oc(oc), .i_drv(o_drv),
		.o_cmp(stage));
	always #20 i_mclk = ~i_mclk;
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wait_mode(input bss_pkg::bss_mode_t m, input int lim);
		for (int n = 0; n < lim && o_mode !== m; n++)
			@(negedge i_mclk);
		check("mode", {5'h00, o_mode}, {5'h00, m});
	endtask
	task automatic restart();
		i_reset_n = 1'b0;
		oc = 1'b0;
		env = 5'h00;
		repeat (20) @(negedge i_mclk);
		check("reset drive", {3'h0, o_drv}, 8'h06);
		i_reset_n = 1'b1;
	endtask
	always @(negedge i_mclk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			finish_test();
		end
	end
	// Drives watched mid-cycle, where they are settled
	always @(negedge i_mclk) begin
		ho_len <= o_drv.top_gate_drive ? ho_len + 1 : 0;
		if (o_drv.top_gate_drive)
			ho_seen <= ho_seen + 1;
		if (o_mode == bss_pkg::BSS_LOCKOUT)
			ho_last <= 0;
		else if (!o_drv.top_gate_drive && ho_len > 0)
			ho_last <= ho_len;
		if (o_drv.bottom_gate_drive)
			lo_len <= lo_len + 1;
		else if (lo_len > 0) begin
			// Pulses cut by fault or lockout are not compared
			if (ho_last > 0 && o_mode != bss_pkg::BSS_FAULT && o_mode != bss_pkg::BSS_LOCKOUT)
				check("duty", 8'(lo_len), 8'(ho_last));
			lo_len <= 0;
		end
		if (o_drv.bottom_gate_drive || o_drv.top_gate_drive) begin
			if (gap > 0) check("deadtime", {7'h00, gap >= DEAD}, 8'h01);
			check("overlap", {7'h00, o_drv.bottom_gate_drive & o_drv.top_gate_drive}, 8'h00);
			check("early top", {7'h00, o_drv.top_gate_drive & ~i_cmp.high_side_ok}, 8'h00);
			gap <= 0;
		end else
			gap <= gap + 1;
	end
	initial begin
		for (int i = 0; i < 4; i++) begin
			restart();
			env = {rows[i][3], rows[i][2], 1'b0, rows[i][1], 1'b0};
			repeat (10) @(negedge i_mclk);
			check("start", {5'h00, o_mode}, {7'h00, rows[i][0]});
			check("timer gnd", {7'h00, o_drv.preheat_timer_discharge}, {7'h00, ~rows[i][0]});
			check("ramp gnd", {7'h00, o_drv.ramp_control_ground}, 8'h01);
		end
		$display("test start table done");
		restart();
		env = 5'h1A;
		wait_mode(bss_pkg::BSS_PREHEAT, 10);
		oc = 1'b1;
		for (int n = 0; n < 2000 && cnt !== 6'h02; n++) @(negedge i_mclk);
		check("count up", {2'h0, cnt}, 8'h02);
		oc = 1'b0;
		for (int n = 0; n < 3000 && cnt !== 6'h00; n++) @(negedge i_mclk);
		check("count down", {2'h0, cnt}, 8'h00);
		wait_mode(bss_pkg::BSS_STRIKE, 9000);
		check("strike dis", {7'h00, o_drv.preheat_timer_discharge}, 8'h01);
		check("ramp free", {7'h00, o_drv.ramp_control_ground}, 8'h00);
		check("top runs", {7'h00, ho_seen > 0}, 8'h01);
		for (int n = 0; n < 300 && o_drv.preheat_timer_discharge !== 1'b0; n++) @(negedge i_mclk);
		check("third", {7'h00, i_cmp.cph_below_one_third}, 8'h01);
		oc = 1'b1;
		for (int n = 0; n < 1500 && o_drv.ramp_control_nudge !== 1'b1; n++) @(negedge i_mclk);
		check("nudge", {7'h00, o_drv.ramp_control_nudge}, 8'h01);
		check("strike count", {2'h0, cnt}, 8'h00);
		oc = 1'b0;
		wait_mode(bss_pkg::BSS_SETTLE, 5000);
		wait_mode(bss_pkg::BSS_STEADY, 3000);
		oc = 1'b1;
		wait_mode(bss_pkg::BSS_FAULT, 6000);
		oc = 1'b0;
		repeat (1000) @(negedge i_mclk);
		check("latched", {4'h0, o_drv.bottom_gate_drive, o_drv.top_gate_drive, o_mode[1:0]}, 8'h01);
		$display("test full run done");
		restart();
		env = 5'h1A;
		wait_mode(bss_pkg::BSS_SETTLE, 12000);
		oc = 1'b1;
		wait_mode(bss_pkg::BSS_FAULT, 1500);
		$display("test settle fault done");
		restart();
		env = 5'h1A;
		wait_mode(bss_pkg::BSS_PREHEAT, 10);
		env = 5'h16;
		wait_mode(bss_pkg::BSS_LOCKOUT, 10);
		$display("test bus drop done");
		finish_test();
	end
endmodule
